/* include/sci_pkg.sv */
package sci_pkg;

  localparam int          DATA_W        = 16;
  localparam int          ADDR_W        = 8;
  localparam int          CODE_W        = 8;
  localparam int          TBL_AW        = 6;
  localparam int          TBL_DEPTH     = 64;

  // Register addresses
  localparam logic [7:0]  ADDR_INT_STAT = 8'h80;
  localparam logic [7:0]  ADDR_INT_EN   = 8'h81;
  localparam logic [7:0]  ADDR_OP_LO    = 8'hB0;
  localparam logic [7:0]  ADDR_OP_HI    = 8'hB1;
  localparam logic [7:0]  ADDR_RESULT   = 8'hB2;
  localparam logic [7:0]  ADDR_CMD      = 8'hB4;

  // Bit of the command-done flag in status and enable
  localparam int          DONE_BIT      = 5;

  // Reset values
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [7:0]  RST_CODE      = 8'h00;
  localparam logic [5:0]  RST_PTR       = 6'h00;

  // Base of the Tx event table within the internal table
  localparam logic [5:0]  TX_SEQ_BASE   = 6'h00;
  localparam logic [5:0]  PTR_STEP      = 6'h01;

  // Command codes
  localparam logic [7:0]  CMD_TBL_WRITE = 8'h04;
  localparam logic [7:0]  CMD_TBL_PAIR  = 8'h08;
  localparam logic [7:0]  CMD_AUX_TIME  = 8'h0D;
  localparam logic [7:0]  CMD_TX_APPLY  = 8'h0F;
  localparam logic [7:0]  CMD_TX_LOAD   = 8'h10;
  localparam logic [7:0]  CMD_STR_WIN   = 8'h12;
  localparam logic [7:0]  CMD_GAIN      = 8'h14;
  localparam logic [7:0]  CMD_BIT_COUNT = 8'h17;
  localparam logic [7:0]  CMD_EYE_MON   = 8'h1F;

  localparam logic [15:0] EYE_OFF       = 16'h0000;
  localparam logic [15:0] EYE_ON        = 16'h0001;

  function automatic logic sci_is_cmd(input logic [7:0] code);
    sci_is_cmd = (code == CMD_TBL_WRITE) || (code == CMD_TBL_PAIR) ||
                 (code == CMD_AUX_TIME) || (code == CMD_TX_APPLY) ||
                 (code == CMD_TX_LOAD) || (code == CMD_STR_WIN) ||
                 (code == CMD_GAIN) || (code == CMD_BIT_COUNT) ||
                 (code == CMD_EYE_MON);
  endfunction : sci_is_cmd

  typedef enum logic [1:0] {
    SCI_IDLE = 2'b00,
    SCI_EXEC = 2'b01,
    SCI_HOLD = 2'b11,
    SCI_DONE = 2'b10
  } sci_dev_state_t;

  typedef enum logic [3:0] {
    SCI_H_INIT  = 4'b0000,
    SCI_H_IDLE  = 4'b0001,
    SCI_H_LO    = 4'b0011,
    SCI_H_HI    = 4'b0010,
    SCI_H_CODE  = 4'b0110,
    SCI_H_WAIT  = 4'b0111,
    SCI_H_RDINT = 4'b0101,
    SCI_H_RDRES = 4'b0100,
    SCI_H_CATCH = 4'b1100
  } sci_host_state_t;

endpackage : sci_pkg

/* include/sci_if.sv */
`timescale 1ns/1ps
interface sci_if;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        host_interrupt_n;

  modport device (
    input  reg_wr,
    input  reg_rd,
    input  reg_addr,
    input  reg_wdata,
    output reg_rdata,
    output reg_rvalid,
    output host_interrupt_n
  );

  modport host (
    output reg_wr,
    output reg_rd,
    output reg_addr,
    output reg_wdata,
    input  reg_rdata,
    input  reg_rvalid,
    input  host_interrupt_n
  );
endinterface : sci_if

/* core/sci_device.sv */
// Contract
// R1: Host writes operands before the command code
// R2: Code write alone starts the command
// R3: Host leaves operands and code alone meanwhile
// R4: Completion sets done, clears code, posts result
// R5: Further command accepted after completion
// R6: Host writes only documented command codes
// R7: Single table write stores low, pointer plus one
// R8: Pair write stores low, high, pointer plus two
// R9: Aux converter timing taken from low operand
// R10: Apply interprets Tx table into Tx control
// R11: Load resets pointer to Tx table base
// R12: Strength window start and length from operands
// R13: Strength and carrier-sense gains from operands
// R14: Host keeps gain operands below 32768
// R15: Bit count waits buffer ready, returns count
// R16: Eye monitor routing on for 1, off for 0
// R17: Operands write-only, result read-only, 16 bits
// R18: Operand, result and code reset to zero
// R19: Done drives interrupt only when enabled
// R20: Code writes during execution are ignored
`timescale 1ns/1ps
module sci_device (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  sci_if.device            bus,
  input  wire logic        msg_buf_ready,
  input  wire logic [15:0] msg_bit_count,
  input  wire logic [5:0]  tx_tbl_addr,
  output logic      [15:0] tx_tbl_data,
  output logic             tx_seq_apply,
  output logic      [5:0]  tx_seq_len,
  output logic      [15:0] aux_conv_setting,
  output logic      [15:0] strength_start,
  output logic      [15:0] strength_length,
  output logic      [15:0] strength_scale,
  output logic      [15:0] carrier_sense_scale,
  output logic             eye_monitor_en,
  output logic             cmd_busy
);

  sci_pkg::sci_dev_state_t state_q;
  logic [15:0]             op_lo_q;
  logic [15:0]             op_hi_q;
  logic [15:0]             result_q;
  logic [7:0]              cmd_q;
  logic [5:0]              ptr_q;
  logic [15:0]             int_en_q;
  logic                    done_flag_q;
  logic [15:0]             rdata_q;
  logic                    rvalid_q;
  logic                    irq_n_q;
  logic [15:0]             tbl_mem [0:sci_pkg::TBL_DEPTH-1];
  logic [15:0]             tx_tbl_data_q;
  logic                    tx_seq_apply_q;
  logic [5:0]              tx_seq_len_q;
  logic [15:0]             aux_conv_q;
  logic [15:0]             str_start_q;
  logic [15:0]             str_len_q;
  logic [15:0]             str_scale_q;
  logic [15:0]             cs_scale_q;
  logic                    eye_en_q;
  logic                    wr_cmd;
  logic                    rd_stat;
  logic                    cmd_busy_q;

  assign wr_cmd  = bus.reg_wr && (bus.reg_addr == sci_pkg::ADDR_CMD);
  assign rd_stat = bus.reg_rd && (bus.reg_addr == sci_pkg::ADDR_INT_STAT);

  // Operand registers accept writes at any time; host keeps them still while busy
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_lo_q <= sci_pkg::RST_WORD; // R18
      op_hi_q <= sci_pkg::RST_WORD; // R18
    end else if (bus.reg_wr) begin
      if (bus.reg_addr == sci_pkg::ADDR_OP_LO) begin
        op_lo_q <= bus.reg_wdata; // R17
      end else if (bus.reg_addr == sci_pkg::ADDR_OP_HI) begin
        op_hi_q <= bus.reg_wdata; // R17
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_en_q <= sci_pkg::RST_WORD;
    end else if (bus.reg_wr && (bus.reg_addr == sci_pkg::ADDR_INT_EN)) begin
      int_en_q <= bus.reg_wdata;
    end
  end

  // Sequencer and command code register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= sci_pkg::SCI_IDLE;
      cmd_q   <= sci_pkg::RST_CODE; // R18
      cmd_busy_q <= 1'b0;
    end else begin
      case (state_q)
        sci_pkg::SCI_IDLE: begin
          if (wr_cmd) begin // R20
            cmd_busy_q <= 1'b1;
            cmd_q   <= bus.reg_wdata[7:0]; // R2
            state_q <= sci_pkg::SCI_EXEC; // R2
          end
        end
        sci_pkg::SCI_EXEC: begin
          if ((cmd_q == sci_pkg::CMD_TBL_PAIR) || (cmd_q == sci_pkg::CMD_BIT_COUNT)) begin
            state_q <= sci_pkg::SCI_HOLD;
          end else begin
            state_q <= sci_pkg::SCI_DONE;
          end
        end
        sci_pkg::SCI_HOLD: begin
          if ((cmd_q != sci_pkg::CMD_BIT_COUNT) || msg_buf_ready) begin
            state_q <= sci_pkg::SCI_DONE; // R15
          end
        end
        sci_pkg::SCI_DONE: begin
          cmd_q   <= sci_pkg::RST_CODE; // R4
          cmd_busy_q <= 1'b0;
          state_q <= sci_pkg::SCI_IDLE; // R5
        end
        default: begin
          state_q <= sci_pkg::SCI_IDLE;
        end
      endcase
    end
  end

  // Internal table and its pointer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_q <= sci_pkg::RST_PTR;
    end else if (state_q == sci_pkg::SCI_EXEC) begin
      if ((cmd_q == sci_pkg::CMD_TBL_WRITE) || (cmd_q == sci_pkg::CMD_TBL_PAIR)) begin
        ptr_q <= ptr_q + sci_pkg::PTR_STEP; // R7 R8
      end else if (cmd_q == sci_pkg::CMD_TX_LOAD) begin
        ptr_q <= sci_pkg::TX_SEQ_BASE; // R11
      end
    end else if ((state_q == sci_pkg::SCI_HOLD) && (cmd_q == sci_pkg::CMD_TBL_PAIR)) begin
      ptr_q <= ptr_q + sci_pkg::PTR_STEP; // R8
    end
  end

  // Table is memory without reset; pair writes take two cycles, one per word
  always_ff @(posedge ref_clk) begin
    if ((state_q == sci_pkg::SCI_EXEC) &&
        ((cmd_q == sci_pkg::CMD_TBL_WRITE) || (cmd_q == sci_pkg::CMD_TBL_PAIR))) begin
      tbl_mem[ptr_q] <= op_lo_q; // R7
    end else if ((state_q == sci_pkg::SCI_HOLD) && (cmd_q == sci_pkg::CMD_TBL_PAIR)) begin
      tbl_mem[ptr_q] <= op_hi_q; // R8
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_tbl_data_q <= sci_pkg::RST_WORD;
    end else begin
      tx_tbl_data_q <= tbl_mem[tx_tbl_addr];
    end
  end

  // Apply hands the loaded entry count to the Tx control logic
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_seq_apply_q <= 1'b0;
      tx_seq_len_q   <= sci_pkg::RST_PTR;
    end else begin
      tx_seq_apply_q <= (state_q == sci_pkg::SCI_EXEC) && (cmd_q == sci_pkg::CMD_TX_APPLY); // R10
      if ((state_q == sci_pkg::SCI_EXEC) && (cmd_q == sci_pkg::CMD_TX_APPLY)) begin
        tx_seq_len_q <= ptr_q - sci_pkg::TX_SEQ_BASE; // R10
      end
    end
  end

  // Datapath settings
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_conv_q  <= sci_pkg::RST_WORD;
      str_start_q <= sci_pkg::RST_WORD;
      str_len_q   <= sci_pkg::RST_WORD;
      str_scale_q <= sci_pkg::RST_WORD;
      cs_scale_q  <= sci_pkg::RST_WORD;
      eye_en_q    <= 1'b0;
    end else if (state_q == sci_pkg::SCI_EXEC) begin
      case (cmd_q)
        sci_pkg::CMD_AUX_TIME: begin
          aux_conv_q <= op_lo_q; // R9
        end
        sci_pkg::CMD_STR_WIN: begin
          str_start_q <= op_lo_q; // R12
          str_len_q   <= op_hi_q; // R12
        end
        sci_pkg::CMD_GAIN: begin
          str_scale_q <= op_lo_q; // R13
          cs_scale_q  <= op_hi_q; // R13
        end
        sci_pkg::CMD_EYE_MON: begin
          // Values other than on or off leave the routing as it was
          if (op_lo_q == sci_pkg::EYE_ON) begin
            eye_en_q <= 1'b1; // R16
          end else if (op_lo_q == sci_pkg::EYE_OFF) begin
            eye_en_q <= 1'b0; // R16
          end
        end
        default: ;
      endcase
    end
  end

  // Result changes only for commands that return data
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q <= sci_pkg::RST_WORD; // R18
    end else if ((state_q == sci_pkg::SCI_HOLD) && (cmd_q == sci_pkg::CMD_BIT_COUNT) &&
                 msg_buf_ready) begin
      result_q <= msg_bit_count; // R15
    end
  end

  // Done flag clears on status read, but a new completion wins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_flag_q <= 1'b0;
    end else if (state_q == sci_pkg::SCI_DONE) begin
      done_flag_q <= 1'b1; // R4
    end else if (rd_stat) begin
      done_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= ~(done_flag_q & int_en_q[sci_pkg::DONE_BIT]); // R19
    end
  end

  // Read port: one cycle latency; write-only and unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q  <= sci_pkg::RST_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.reg_rd;
      if (!bus.reg_rd) begin
        rdata_q <= sci_pkg::RST_WORD;
      end else if (bus.reg_addr == sci_pkg::ADDR_RESULT) begin
        rdata_q <= result_q; // R17
      end else if (bus.reg_addr == sci_pkg::ADDR_INT_STAT) begin
        rdata_q <= 16'(done_flag_q) << sci_pkg::DONE_BIT;
      end else begin
        rdata_q <= sci_pkg::RST_WORD; // R17
      end
    end
  end

  assign bus.reg_rdata        = rdata_q;
  assign bus.reg_rvalid       = rvalid_q;
  assign bus.host_interrupt_n = irq_n_q;
  assign tx_tbl_data          = tx_tbl_data_q;
  assign tx_seq_apply         = tx_seq_apply_q;
  assign tx_seq_len           = tx_seq_len_q;
  assign aux_conv_setting     = aux_conv_q;
  assign strength_start       = str_start_q;
  assign strength_length      = str_len_q;
  assign strength_scale       = str_scale_q;
  assign carrier_sense_scale  = cs_scale_q;
  assign eye_monitor_en       = eye_en_q;
  assign cmd_busy             = cmd_busy_q;

endmodule : sci_device

/* core/sci_host.sv */
`timescale 1ns/1ps
module sci_host (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  sci_if.host              bus,
  input  wire logic        cmd_req,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_op_lo,
  input  wire logic [15:0] cmd_op_hi,
  output logic             cmd_ready,
  output logic             cmd_done,
  output logic             cmd_err,
  output logic      [15:0] cmd_result
);

  sci_pkg::sci_host_state_t state_q;
  logic                     wr_q;
  logic                     rd_q;
  logic [7:0]               addr_q;
  logic [15:0]              wdata_q;
  logic [7:0]               code_q;
  logic [15:0]              lo_q;
  logic [15:0]              hi_q;
  logic                     ready_q;
  logic                     done_q;
  logic                     err_q;
  logic [15:0]              result_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q  <= sci_pkg::SCI_H_INIT;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      addr_q   <= 8'h00;
      wdata_q  <= sci_pkg::RST_WORD;
      code_q   <= sci_pkg::RST_CODE;
      lo_q     <= sci_pkg::RST_WORD;
      hi_q     <= sci_pkg::RST_WORD;
      ready_q  <= 1'b0;
      done_q   <= 1'b0;
      err_q    <= 1'b0;
      result_q <= sci_pkg::RST_WORD;
    end else begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
      case (state_q)
        sci_pkg::SCI_H_INIT: begin
          // Completion is seen through the interrupt, so enable it first
          wr_q    <= 1'b1;
          addr_q  <= sci_pkg::ADDR_INT_EN;
          wdata_q <= 16'h0001 << sci_pkg::DONE_BIT; // R19
          ready_q <= 1'b1;
          state_q <= sci_pkg::SCI_H_IDLE;
        end
        sci_pkg::SCI_H_IDLE: begin
          if (cmd_req && !sci_pkg::sci_is_cmd(cmd_code)) begin
            err_q <= 1'b1; // R6
          end else if (cmd_req) begin
            code_q  <= cmd_code;
            // Gain commands keep the top operand bit clear
            lo_q    <= (cmd_code == sci_pkg::CMD_GAIN) ? {1'b0, cmd_op_lo[14:0]} : cmd_op_lo; // R14
            hi_q    <= (cmd_code == sci_pkg::CMD_GAIN) ? {1'b0, cmd_op_hi[14:0]} : cmd_op_hi; // R14
            ready_q <= 1'b0;
            state_q <= sci_pkg::SCI_H_LO;
          end
        end
        sci_pkg::SCI_H_LO: begin
          wr_q    <= 1'b1;
          addr_q  <= sci_pkg::ADDR_OP_LO; // R1
          wdata_q <= lo_q;
          state_q <= sci_pkg::SCI_H_HI;
        end
        sci_pkg::SCI_H_HI: begin
          wr_q    <= 1'b1;
          addr_q  <= sci_pkg::ADDR_OP_HI; // R1
          wdata_q <= hi_q;
          state_q <= sci_pkg::SCI_H_CODE;
        end
        sci_pkg::SCI_H_CODE: begin
          wr_q    <= 1'b1;
          addr_q  <= sci_pkg::ADDR_CMD; // R1
          wdata_q <= {8'h00, code_q};
          state_q <= sci_pkg::SCI_H_WAIT;
        end
        sci_pkg::SCI_H_WAIT: begin
          // No bus writes here, so registers stay still while busy
          if (!bus.host_interrupt_n) begin
            state_q <= sci_pkg::SCI_H_RDINT; // R3
          end
        end
        sci_pkg::SCI_H_RDINT: begin
          rd_q    <= 1'b1;
          addr_q  <= sci_pkg::ADDR_INT_STAT;
          state_q <= sci_pkg::SCI_H_RDRES;
        end
        sci_pkg::SCI_H_RDRES: begin
          rd_q    <= 1'b1;
          addr_q  <= sci_pkg::ADDR_RESULT;
          state_q <= sci_pkg::SCI_H_CATCH;
        end
        sci_pkg::SCI_H_CATCH: begin
          if (bus.reg_rvalid && !rd_q) begin
            result_q <= bus.reg_rdata;
            done_q   <= 1'b1;
            ready_q  <= 1'b1;
            state_q  <= sci_pkg::SCI_H_IDLE;
          end
        end
        default: begin
          state_q <= sci_pkg::SCI_H_INIT;
        end
      endcase
    end
  end

  assign bus.reg_wr    = wr_q;
  assign bus.reg_rd    = rd_q;
  assign bus.reg_addr  = addr_q;
  assign bus.reg_wdata = wdata_q;
  assign cmd_ready     = ready_q;
  assign cmd_done      = done_q;
  assign cmd_err       = err_q;
  assign cmd_result    = result_q;

endmodule : sci_host

/* tb/sci_chk.sv */
`timescale 1ns/1ps
module sci_chk (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        host_interrupt_n
);
  logic pend_q;
  logic en_q;

  // Busy window as the host sees it: code write until status read
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) pend_q <= 1'b0;
    else if (reg_wr && reg_addr == sci_pkg::ADDR_CMD) pend_q <= 1'b1;
    else if (reg_rd && reg_addr == sci_pkg::ADDR_INT_STAT) pend_q <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) en_q <= 1'b0;
    else if (reg_wr && reg_addr == sci_pkg::ADDR_INT_EN) en_q <= reg_wdata[sci_pkg::DONE_BIT];
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  chk_code_after_ops: assert property (
    reg_wr && reg_addr == sci_pkg::ADDR_CMD |->
      $past(reg_wr) && $past(reg_addr) == sci_pkg::ADDR_OP_HI)
    else $error("code write not preceded by operand write");
  chk_cmd_completes: assert property (
    reg_wr && reg_addr == sci_pkg::ADDR_CMD |-> ##[3:200] !host_interrupt_n)
    else $error("command did not complete");
  chk_ops_held_busy: assert property (
    pend_q |-> !(reg_wr && (reg_addr == sci_pkg::ADDR_OP_LO ||
      reg_addr == sci_pkg::ADDR_OP_HI || reg_addr == sci_pkg::ADDR_CMD)))
    else $error("operand or code written while busy");
  chk_done_flag_read: assert property (
    reg_rvalid && $past(reg_rd) && $past(reg_addr) == sci_pkg::ADDR_INT_STAT |->
      reg_rdata[sci_pkg::DONE_BIT])
    else $error("done flag not set on status read");
  chk_irq_enabled: assert property (!host_interrupt_n |-> en_q)
    else $error("interrupt low while disabled");
  chk_irq_after_code: assert property ($fell(host_interrupt_n) |-> pend_q)
    else $error("interrupt without command");
  chk_rvalid_after_read: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without read");
  chk_rdata_idle: assert property (!reg_rvalid |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer");
  chk_rd_wr_apart: assert property (!(reg_rd && reg_wr))
    else $error("read and write together");
endmodule : sci_chk

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic        ref_clk, arst_n, cmd_req, msg_buf_ready, tx_seq_apply, eye_monitor_en, cmd_busy;
  logic        cmd_ready, cmd_done, cmd_err;
  logic [7:0]  cmd_code;
  logic [5:0]  tx_tbl_addr, tx_seq_len;
  logic [15:0] cmd_op_lo, cmd_op_hi, msg_bit_count, cmd_result, tx_tbl_data, aux_conv_setting;
  logic [15:0] strength_start, strength_length, strength_scale, carrier_sense_scale;
  logic [31:0] seed;
  int          failures, n_checks, n_wr, n_apply, i;
  int          m_tbl[64];
  int          m_ptr, m_aux, m_st, m_len, m_ss, m_cs, m_eye, m_res;

  sci_if bus_if ();
  sci_device u_sci_device (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus_if),
    .msg_buf_ready(msg_buf_ready), .msg_bit_count(msg_bit_count), .tx_tbl_addr(tx_tbl_addr),
    .tx_tbl_data(tx_tbl_data), .tx_seq_apply(tx_seq_apply), .tx_seq_len(tx_seq_len),
    .aux_conv_setting(aux_conv_setting), .strength_start(strength_start),
    .strength_length(strength_length), .strength_scale(strength_scale),
    .carrier_sense_scale(carrier_sense_scale), .eye_monitor_en(eye_monitor_en),
    .cmd_busy(cmd_busy));
  sci_host u_sci_host (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus_if), .cmd_req(cmd_req),
    .cmd_code(cmd_code), .cmd_op_lo(cmd_op_lo), .cmd_op_hi(cmd_op_hi), .cmd_ready(cmd_ready),
    .cmd_done(cmd_done), .cmd_err(cmd_err), .cmd_result(cmd_result));
  sci_chk u_sci_chk (.ref_clk(ref_clk), .arst_n(arst_n), .reg_wr(bus_if.reg_wr),
    .reg_rd(bus_if.reg_rd), .reg_addr(bus_if.reg_addr), .reg_wdata(bus_if.reg_wdata),
    .reg_rdata(bus_if.reg_rdata), .reg_rvalid(bus_if.reg_rvalid),
    .host_interrupt_n(bus_if.host_interrupt_n));

  always #10 ref_clk = ~ref_clk;

  // Wire-side traffic counters, judged per command
  always @(posedge ref_clk) begin
    if (bus_if.reg_wr === 1'b1) n_wr++;
    if (tx_seq_apply === 1'b1) n_apply++;
  end

  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    rnd = seed[15:0];
  endfunction : rnd

  function automatic logic known_code(input logic [7:0] c);
    known_code = c inside {8'h04, 8'h08, 8'h0D, 8'h0F, 8'h10, 8'h12, 8'h14, 8'h17, 8'h1F};
  endfunction : known_code

  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_cmd(input logic [7:0] c, input logic [15:0] lo, input logic [15:0] hi);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 100) begin
      failures++;
      wrap_up();
    end
    @(posedge ref_clk);
    cmd_req <= 1'b1;
    cmd_code <= c;
    cmd_op_lo <= lo;
    cmd_op_hi <= hi;
    @(posedge ref_clk);
    cmd_req <= 1'b0;
    #1;
    n = 0;
    // Bounded wait; a hang is a failure, not a stall
    while (cmd_done !== 1'b1 && cmd_err !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (n >= 300) begin
      failures++;
      wrap_up();
    end
  endtask : do_cmd

  task automatic run(input logic [7:0] c, input logic [15:0] lo, input logic [15:0] hi);
    int  w0, a0;
    logic k;
    w0 = n_wr;
    a0 = n_apply;
    k = known_code(c);
    do_cmd(c, lo, hi);
    check(cmd_err, !k);
    check(16'(n_wr - w0), k ? 16'h0003 : 16'h0000);
    if (k) begin
      case (c)
        8'h04: begin m_tbl[m_ptr] = lo; m_ptr = (m_ptr + 1) % 64; end
        8'h08: begin m_tbl[m_ptr] = lo; m_tbl[(m_ptr + 1) % 64] = hi; m_ptr = (m_ptr + 2) % 64; end
        8'h0D: m_aux = lo;
        8'h10: m_ptr = 0;
        8'h12: begin m_st = lo; m_len = hi; end
        8'h14: begin m_ss = lo & 16'h7FFF; m_cs = hi & 16'h7FFF; end
        8'h17: m_res = msg_bit_count;
        8'h1F: m_eye = (lo == 16'h0000) ? 0 : (lo == 16'h0001) ? 1 : m_eye;
        default: ;
      endcase
    end
    if (c == 8'h0F) begin
      check(16'(n_apply - a0), 16'h0001);
      check({10'h000, tx_seq_len}, 16'(m_ptr));
    end
    check(aux_conv_setting, 16'(m_aux));
    check(strength_start, 16'(m_st));
    check(strength_length, 16'(m_len));
    check(strength_scale, 16'(m_ss));
    check(carrier_sense_scale, 16'(m_cs));
    check(eye_monitor_en, 16'(m_eye));
    check(cmd_result, 16'(m_res));
  endtask : run

  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    cmd_req = 1'b0;
    cmd_code = 8'h00;
    cmd_op_lo = 16'h0000;
    cmd_op_hi = 16'h0000;
    msg_buf_ready = 1'b0;
    msg_bit_count = 16'h0000;
    tx_tbl_addr = 6'h00;
    seed = 32'h0001_0206;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1 check(cmd_result, 16'h0000);
    check(aux_conv_setting | strength_scale | strength_start, 16'h0000);
    check(bus_if.host_interrupt_n, 16'h0001);
    // Enable write after reset must not count against the first command
    repeat (2) @(posedge ref_clk);
    #1 check(cmd_ready, 16'h0001);
    run(8'h10, rnd(), rnd());
    run(8'h04, rnd(), rnd());
    run(8'h04, rnd(), rnd());
    run(8'h08, rnd(), rnd());
    run(8'h0F, rnd(), rnd());
    for (i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      tx_tbl_addr <= 6'(i);
      @(posedge ref_clk);
      @(posedge ref_clk);
      #1 check(tx_tbl_data, 16'(m_tbl[i]));
    end
    // Extremes of the legal converter range
    run(8'h0D, 16'h0018, rnd());
    run(8'h0D, 16'h0100, rnd());
    run(8'h12, rnd(), rnd());
    run(8'h14, rnd() & 16'h7FFF, rnd() & 16'h7FFF);
    run(8'h1F, 16'h0001, rnd());
    run(8'h1F, 16'h0005, rnd());
    run(8'h1F, 16'h0000, rnd());
    run(8'h05, rnd(), rnd());
    run(8'hFF, rnd(), rnd());
    fork
      run(8'h17, rnd(), rnd());
      begin
        repeat (12) @(posedge ref_clk);
        #1 check(cmd_busy, 16'h0001);
        @(posedge ref_clk);
        msg_bit_count <= rnd();
        msg_buf_ready <= 1'b1;
      end
    join
    // Result must survive a later command that returns nothing
    run(8'h12, rnd(), rnd());
    wrap_up();
  end
endmodule : testbench
